// file: hdl/motion_start_handler.sv
// Purpose: Decode start inputs into positioning and homing launches
// Assumes: Motion generator answers with op_done and motor_at_rest
// Notes: APB slave holds homing configuration and direct maps
//
// Functional notes
// - Start launches move with selected data number
// - Unhomed start alarms only when enabled
// - Sequential start uses next data number
// - Direct input starts its mapped move
// - Six maps 0..63, reset 0 to 5
// - Home input starts homing sequence
// - Home flag after completion and rest
// - Mode field picks homing method
// - Homing speed 1 to 1000000, reset 1000
// - Homing accel 1 to 1000000, reset 1000
// - Homing start speed range, reset 500
// - Signed 24-bit home offset, reset 0
// - Search direction bit, reset positive
// - Aperture sensor use bit, reset off
// - Phase pulse use bit, reset off
// - Push current 0..1000 tenths percent
//
// Implementation choices: register access over APB and the address map.

`timescale 1ns/1ps

module motion_start_handler (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic start_input,
    input wire logic sequential_start_input,
    input wire logic [5:0] direct_select_inputs,
    input wire logic home_input,
    input wire logic [5:0] data_number_select_inputs,
    input wire logic op_done,
    input wire logic motor_at_rest,
    output logic move_start,
    output logic [5:0] move_data_no,
    output logic home_start,
    output logic home_position_flag,
    output logic home_incomplete_alarm,
    output logic irq,
    output logic [1:0] home_mode,
    output logic [19:0] home_speed,
    output logic [19:0] home_accel,
    output logic [19:0] home_start_speed,
    output logic [23:0] home_offset,
    output logic home_dir,
    output logic index_aperture_input_use,
    output logic tim_use,
    output logic [9:0] push_current
);

    logic [8:0] trig_level, trig_rise;
    logic [5:0] sel_no, direct_rise;
    logic start_rise, seq_rise, home_rise;
    // Pin synchronisers
    input_edge_sync #(.W(9)) u_trig_sync (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .pin_in({direct_select_inputs, home_input, sequential_start_input, start_input}),
        .level(trig_level),
        .rise(trig_rise)
    );
    input_edge_sync #(.W(6)) u_no_sync (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .pin_in(data_number_select_inputs),
        .level(sel_no),
        .rise()
    );
    assign start_rise = trig_rise[0];
    assign seq_rise = trig_rise[1];
    assign home_rise = trig_rise[2];
    assign direct_rise = trig_rise[8:3];
    // Configuration registers
    logic alarm_en_q, dir_q, index_aperture_input_q, tim_q;
    logic [1:0] mode_q;
    logic [19:0] speed_q, accel_q, start_speed_q;
    logic [23:0] offset_q;
    logic [9:0] current_q;
    logic [5:0] map_q [6];
    // APB handshake: one wait cycle, then pready
    logic pready_q, pslverr_q, access, wr_take, mapped;
    logic [31:0] prdata_q, rdata_d;
    logic ctrl_wr, irq_clear_wr, irq_enable_wr;
    assign access = psel & penable;
    assign wr_take = access & pready_q & pwrite & ~pslverr_q;
    assign ctrl_wr = wr_take & (paddr == motion_start_pkg::CTRL_OFS);
    assign irq_clear_wr = wr_take & (paddr == motion_start_pkg::IRQ_CLEAR_OFS);
    assign irq_enable_wr = wr_take & (paddr == motion_start_pkg::IRQ_ENABLE_OFS);
    // Operation state
    logic busy_q, homing_q, homed_pend_q, home_flag_q, alarm_q;
    logic move_start_q, home_start_q, irq_q;
    logic [5:0] move_no_q, last_no_q;
    logic [3:0] irq_status, irq_enable;

    always_comb begin
        mapped = 1'b1;
        rdata_d = 32'h0000_0000;
        unique case (paddr)
            motion_start_pkg::CTRL_OFS: begin
                rdata_d[motion_start_pkg::CTRL_ALARM_EN_BIT] = alarm_en_q;
                rdata_d[motion_start_pkg::CTRL_MODE_LSB +: 2] = mode_q;
                rdata_d[motion_start_pkg::CTRL_DIR_BIT] = dir_q;
                rdata_d[motion_start_pkg::CTRL_INDEX_APERTURE_INPUT_BIT] = index_aperture_input_q;
                rdata_d[motion_start_pkg::CTRL_TIM_BIT] = tim_q;
            end
            motion_start_pkg::HOME_SPEED_OFS: rdata_d[19:0] = speed_q;
            motion_start_pkg::HOME_ACCEL_OFS: rdata_d[19:0] = accel_q;
            motion_start_pkg::HOME_START_SPEED_OFS: rdata_d[19:0] = start_speed_q;
            motion_start_pkg::HOME_OFFSET_OFS: rdata_d[23:0] = offset_q;
            motion_start_pkg::PUSH_CURRENT_OFS: rdata_d[9:0] = current_q;
            motion_start_pkg::STATUS_OFS: begin
                rdata_d[motion_start_pkg::STAT_HOME_BIT] = home_flag_q;
                rdata_d[motion_start_pkg::STAT_BUSY_BIT] = busy_q;
                rdata_d[motion_start_pkg::STAT_ALARM_BIT] = alarm_q;
                rdata_d[motion_start_pkg::STAT_NO_LSB +: 6] = move_no_q;
            end
            motion_start_pkg::IRQ_STATUS_OFS: rdata_d[3:0] = irq_status;
            motion_start_pkg::IRQ_ENABLE_OFS: rdata_d[3:0] = irq_enable;
            motion_start_pkg::IRQ_CLEAR_OFS: rdata_d = 32'h0000_0000;
            default: begin
                mapped = 1'b0;
                for (int k = 0; k < 6; k++) begin
                    if (paddr == motion_start_pkg::DIRECT_MAP_BASE + 8'(4 * k)) begin
                        mapped = 1'b1;
                        rdata_d[5:0] = map_q[k];
                    end
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else begin
            pready_q <= access & ~pready_q;
            pslverr_q <= access & ~pready_q & ~mapped;
            if (access & ~pready_q) begin
                prdata_q <= pwrite ? 32'h0000_0000 : rdata_d;
            end
        end
    end
    // Control register and homing parameters
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            alarm_en_q <= motion_start_pkg::RST_ALARM_EN;
            mode_q <= motion_start_pkg::RST_MODE;
            dir_q <= motion_start_pkg::RST_DIR;
            index_aperture_input_q <= motion_start_pkg::RST_INDEX_APERTURE_INPUT;
            tim_q <= motion_start_pkg::RST_TIM;
        end else if (ctrl_wr) begin
            alarm_en_q <= pwdata[motion_start_pkg::CTRL_ALARM_EN_BIT];
            if (pwdata[motion_start_pkg::CTRL_MODE_LSB +: 2] != 2'h3) begin
                mode_q <= pwdata[motion_start_pkg::CTRL_MODE_LSB +: 2];
            end
            dir_q <= pwdata[motion_start_pkg::CTRL_DIR_BIT];
            index_aperture_input_q <= pwdata[motion_start_pkg::CTRL_INDEX_APERTURE_INPUT_BIT];
            tim_q <= pwdata[motion_start_pkg::CTRL_TIM_BIT];
        end
    end
    // Out-of-range writes leave the old value
    function automatic logic in_speed(input logic [31:0] v);
        in_speed = (v >= motion_start_pkg::SPEED_MIN) && (v <= motion_start_pkg::SPEED_MAX);
    endfunction : in_speed
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            speed_q <= motion_start_pkg::RST_HOME_SPEED;
            accel_q <= motion_start_pkg::RST_HOME_ACCEL;
            start_speed_q <= motion_start_pkg::RST_HOME_START_SPEED;
            offset_q <= motion_start_pkg::RST_HOME_OFFSET;
            current_q <= motion_start_pkg::RST_PUSH_CURRENT;
        end else if (wr_take) begin
            if (paddr == motion_start_pkg::HOME_SPEED_OFS && in_speed(pwdata)) begin
                speed_q <= pwdata[19:0];
            end
            if (paddr == motion_start_pkg::HOME_ACCEL_OFS && in_speed(pwdata)) begin
                accel_q <= pwdata[19:0];
            end
            if (paddr == motion_start_pkg::HOME_START_SPEED_OFS && in_speed(pwdata)) begin
                start_speed_q <= pwdata[19:0];
            end
            if (paddr == motion_start_pkg::HOME_OFFSET_OFS) begin
                offset_q <= pwdata[23:0];
            end
            if (paddr == motion_start_pkg::PUSH_CURRENT_OFS
                    && pwdata <= motion_start_pkg::CURRENT_MAX) begin
                current_q <= pwdata[9:0];
            end
        end
    end
    // Direct input number maps
    genvar g;
    generate
        for (g = 0; g < 6; g++) begin : g_map
            always_ff @(posedge clk_sys) begin
                if (!resetn) begin
                    map_q[g] <= 6'(g);
                end else if (wr_take
                        && paddr == motion_start_pkg::DIRECT_MAP_BASE + 8'(4 * g)) begin
                    map_q[g] <= pwdata[5:0];
                end
            end
        end
    endgenerate
    // Start request selection: start, then direct, then sequential
    logic pos_req, alarm_trip;
    logic [5:0] direct_no, req_no;
    always_comb begin
        direct_no = 6'h00;
        for (int k = 5; k >= 0; k--) begin
            if (direct_rise[k]) begin
                direct_no = map_q[k];
            end
        end
    end
    assign pos_req = start_rise | seq_rise | (|direct_rise);
    assign alarm_trip = alarm_en_q & ~home_flag_q;
    always_comb begin
        if (start_rise) begin
            req_no = sel_no;
        end else if (|direct_rise) begin
            req_no = direct_no;
        end else begin
            req_no = last_no_q + 6'h01;
        end
    end
    logic launch_ok, alarm_evt, homed_evt;
    assign launch_ok = ~busy_q & ~home_rise & pos_req & ~alarm_trip;
    assign alarm_evt = ~busy_q & ~home_rise & pos_req & alarm_trip;
    assign homed_evt = homed_pend_q & motor_at_rest & ~home_flag_q;
    // Launch and busy tracking
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            busy_q <= 1'b0;
            homing_q <= 1'b0;
            move_start_q <= 1'b0;
            home_start_q <= 1'b0;
            move_no_q <= 6'h00;
            last_no_q <= motion_start_pkg::RST_LAST_NO;
        end else begin
            move_start_q <= 1'b0;
            home_start_q <= 1'b0;
            if (busy_q) begin
                if (op_done) begin
                    busy_q <= 1'b0;
                    homing_q <= 1'b0;
                end
            end else if (home_rise) begin
                home_start_q <= 1'b1;
                busy_q <= 1'b1;
                homing_q <= 1'b1;
            end else if (launch_ok) begin
                move_start_q <= 1'b1;
                busy_q <= 1'b1;
                move_no_q <= req_no;
                last_no_q <= req_no;
            end
        end
    end
    // Home flag after completion and rest; alarm latch
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            homed_pend_q <= 1'b0;
            home_flag_q <= 1'b0;
            alarm_q <= 1'b0;
        end else begin
            if (~busy_q & home_rise) begin
                homed_pend_q <= 1'b0;
                home_flag_q <= 1'b0;
            end else if (homing_q & op_done) begin
                homed_pend_q <= 1'b1;
            end else if (homed_evt) begin
                homed_pend_q <= 1'b0;
                home_flag_q <= 1'b1;
            end
            if (alarm_evt) begin
                alarm_q <= 1'b1;
            end else if (ctrl_wr & pwdata[motion_start_pkg::CTRL_ALARM_CLR_BIT]) begin
                alarm_q <= 1'b0;
            end
        end
    end
    event_irq_regs #(.W(4)) u_irq (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .event_set({alarm_evt, homed_evt, op_done & busy_q, launch_ok}),
        .clear_wr(irq_clear_wr),
        .enable_wr(irq_enable_wr),
        .wdata(pwdata[3:0]),
        .status_q(irq_status),
        .enable_q(irq_enable),
        .irq_q(irq_q)
    );
    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign move_start = move_start_q;
    assign move_data_no = move_no_q;
    assign home_start = home_start_q;
    assign home_position_flag = home_flag_q;
    assign home_incomplete_alarm = alarm_q;
    assign irq = irq_q;
    assign home_mode = mode_q;
    assign home_speed = speed_q;
    assign home_accel = accel_q;
    assign home_start_speed = start_speed_q;
    assign home_offset = offset_q;
    assign home_dir = dir_q;
    assign index_aperture_input_use = index_aperture_input_q;
    assign tim_use = tim_q;
    assign push_current = current_q;
    // Checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    start_move_a: assert property (
        start_rise && launch_ok |=> move_start_q && move_no_q == $past(sel_no))
        else $error("start did not launch selected number");
    alarm_gate_a: assert property (alarm_evt |=> alarm_q && !move_start_q)
        else $error("unhomed start with alarm enabled misbehaved");
    alarm_off_a: assert property (!alarm_en_q && !alarm_q |=> !alarm_q)
        else $error("alarm raised while disabled");
    seq_next_a: assert property (
        seq_rise && !start_rise && direct_rise == 6'h00 && launch_ok
        |=> move_no_q == $past(last_no_q) + 6'h01)
        else $error("sequential start used wrong number");
    direct_map_a: assert property (
        !start_rise && direct_rise != 6'h00 && launch_ok
        |=> move_start_q && move_no_q == $past(direct_no))
        else $error("direct start used wrong map");
    home_launch_a: assert property (
        home_rise && !busy_q |=> home_start_q ##1 !home_start_q)
        else $error("home input did not start homing once");
    flag_rest_a: assert property (
        $rose(home_flag_q) |-> $past(motor_at_rest) && $past(homed_pend_q))
        else $error("home flag set before rest");
    mode_legal_a: assert property (mode_q != 2'h3)
        else $error("illegal homing mode held");
    speed_range_a: assert property (
        speed_q >= 20'h00001 && start_speed_q >= 20'h00001 && accel_q >= 20'h00001)
        else $error("homing speed out of range");
    current_range_a: assert property (current_q <= 10'h3e8)
        else $error("push current out of range");
    single_pulse_a: assert property (move_start_q |=> !move_start_q)
        else $error("held start launched twice");
    seq_cover_c: cover property (seq_rise ##[1:200] move_start_q);
    home_cover_c: cover property (home_start_q ##[1:500] home_flag_q);
    alarm_cover_c: cover property (alarm_evt ##1 irq_q);

endmodule : motion_start_handler

// file: common/motion_start_pkg.sv
// Purpose: Shared constants for the motion start input handler
// Assumes: APB byte addresses, 32-bit data, one word per register
// Notes: Ranges and reset values of the homing configuration

package motion_start_pkg;

    localparam int ADDR_W = 8;
    localparam int NO_W = 6;
    localparam int DIRECT_N = 6;
    localparam int SPEED_W = 20;
    localparam int OFFSET_W = 24;
    localparam int CURRENT_W = 10;
    localparam int EVT_N = 4;

    // Register byte offsets
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] HOME_SPEED_OFS = 8'h04;
    localparam logic [7:0] HOME_ACCEL_OFS = 8'h08;
    localparam logic [7:0] HOME_START_SPEED_OFS = 8'h0c;
    localparam logic [7:0] HOME_OFFSET_OFS = 8'h10;
    localparam logic [7:0] PUSH_CURRENT_OFS = 8'h14;
    localparam logic [7:0] DIRECT_MAP_BASE = 8'h20;
    localparam logic [7:0] STATUS_OFS = 8'h40;
    localparam logic [7:0] IRQ_STATUS_OFS = 8'h44;
    localparam logic [7:0] IRQ_ENABLE_OFS = 8'h48;
    localparam logic [7:0] IRQ_CLEAR_OFS = 8'h4c;

    // Control register fields
    localparam int CTRL_ALARM_EN_BIT = 0;
    localparam int CTRL_MODE_LSB = 1;
    localparam int CTRL_DIR_BIT = 3;
    localparam int CTRL_INDEX_APERTURE_INPUT_BIT = 4;
    localparam int CTRL_TIM_BIT = 5;
    localparam int CTRL_ALARM_CLR_BIT = 6;

    // Status register fields
    localparam int STAT_HOME_BIT = 0;
    localparam int STAT_BUSY_BIT = 1;
    localparam int STAT_ALARM_BIT = 2;
    localparam int STAT_NO_LSB = 8;

    // Interrupt event bits
    localparam int EVT_MOVE_START = 0;
    localparam int EVT_OP_DONE = 1;
    localparam int EVT_HOMED = 2;
    localparam int EVT_ALARM = 3;

    // Homing modes
    localparam logic [1:0] MODE_TWO_SENSOR = 2'h0;
    localparam logic [1:0] MODE_THREE_SENSOR = 2'h1;
    localparam logic [1:0] MODE_PUSH = 2'h2;

    // Limits
    localparam logic [31:0] SPEED_MIN = 32'h0000_0001;
    localparam logic [31:0] SPEED_MAX = 32'h000f_4240;
    localparam logic [31:0] CURRENT_MAX = 32'h0000_03e8;

    // Reset values
    localparam logic RST_ALARM_EN = 1'b0;
    localparam logic [1:0] RST_MODE = MODE_THREE_SENSOR;
    localparam logic [SPEED_W-1:0] RST_HOME_SPEED = 20'h003e8;
    localparam logic [SPEED_W-1:0] RST_HOME_ACCEL = 20'h003e8;
    localparam logic [SPEED_W-1:0] RST_HOME_START_SPEED = 20'h001f4;
    localparam logic [OFFSET_W-1:0] RST_HOME_OFFSET = 24'h000000;
    localparam logic RST_DIR = 1'b1;
    localparam logic RST_INDEX_APERTURE_INPUT = 1'b0;
    localparam logic RST_TIM = 1'b0;
    localparam logic [CURRENT_W-1:0] RST_PUSH_CURRENT = 10'h3e8;
    localparam logic [NO_W-1:0] RST_LAST_NO = 6'h3f;

endpackage : motion_start_pkg

// file: hdl/input_edge_sync.sv
// Purpose: Two-stage synchroniser with rising edge detect per bit
// Assumes: Inputs asynchronous to clk_sys
// Notes: First stage feeds only the second stage

`timescale 1ns/1ps

module input_edge_sync #(
    parameter int W = 1
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic [W-1:0] pin_in,
    output logic [W-1:0] level,
    output logic [W-1:0] rise
);

    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            logic meta_q;
            logic sync_q;
            logic prev_q;
            always_ff @(posedge clk_sys) begin
                if (!resetn) begin
                    meta_q <= 1'b0;
                    sync_q <= 1'b0;
                    prev_q <= 1'b0;
                end else begin
                    meta_q <= pin_in[i];
                    sync_q <= meta_q;
                    prev_q <= sync_q;
                end
            end
            assign level[i] = sync_q;
            assign rise[i] = sync_q & ~prev_q;
        end
    endgenerate

endmodule : input_edge_sync

// file: hdl/event_irq_regs.sv
// Purpose: Sticky event status, enable mask and level interrupt
// Assumes: Write strobes are single-cycle
// Notes: A set in the clearing cycle wins

`timescale 1ns/1ps

module event_irq_regs #(
    parameter int W = 4
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic [W-1:0] event_set,
    input wire logic clear_wr,
    input wire logic enable_wr,
    input wire logic [W-1:0] wdata,
    output logic [W-1:0] status_q,
    output logic [W-1:0] enable_q,
    output logic irq_q
);

    logic [W-1:0] status_d;

    always_comb begin
        status_d = status_q;
        if (clear_wr) begin
            status_d = status_d & ~wdata;
        end
        status_d = status_d | event_set;
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            status_q <= '0;
            enable_q <= '0;
            irq_q <= 1'b0;
        end else begin
            status_q <= status_d;
            if (enable_wr) begin
                enable_q <= wdata;
            end
            irq_q <= |(status_d & (enable_wr ? wdata : enable_q));
        end
    end

endmodule : event_irq_regs

// file: verification/motion_gen_model.sv
// Purpose: Motion generator stand-in closing each launch
// Assumes: Launch pulses last one cycle
// Notes: Finish delay comes from the bench per move
`timescale 1ns/1ps
module motion_gen_model (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic move_start,
    input wire logic home_start,
    input wire logic [7:0] op_delay,
    output logic op_done,
    output logic motor_at_rest
);
    logic [7:0] left_q;
    assign motor_at_rest = (left_q == 8'h00);
    always @(posedge clk_sys) begin
        op_done <= resetn && (left_q == 8'h01);
        if (!resetn) begin
            left_q <= 8'h00;
        end else if (move_start || home_start) begin
            left_q <= op_delay;
        end else if (left_q != 8'h00) begin
            left_q <= left_q - 8'h01;
        end
    end
endmodule : motion_gen_model

// file: verification/test_motion_start_handler.sv
// Purpose: Self-checking bench for the motion start handler
// Assumes: Motion generator model closes every launch
// Notes: Driver queues launch notes, a monitor compares them
`timescale 1ns/1ps
module test_motion_start_handler;
    logic clk_sys = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00, op_delay = 8'h20;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, err, op_done, motor_at_rest, move_start, home_start;
    logic start_input = 1'b0, sequential_start_input = 1'b0, home_input = 1'b0;
    logic [5:0] direct_select_inputs = 6'h00, data_number_select_inputs = 6'h00;
    logic home_position_flag, home_incomplete_alarm, irq, home_dir, index_aperture_input_use, tim_use;
    logic [5:0] move_data_no, n;
    logic [1:0] home_mode;
    logic [19:0] home_speed, home_accel, home_start_speed;
    logic [23:0] home_offset;
    logic [9:0] push_current;
    logic [6:0] exp_q[$];
    logic [7:0] ra[6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14};
    logic [31:0] rv[6] = '{32'h0a, 32'h3e8, 32'h3e8, 32'h1f4, 32'h0, 32'h3e8};
    int errors = 0, checked = 0, k;
    always #5 clk_sys = ~clk_sys;
    motion_start_handler dut_u (.clk_sys, .resetn, .paddr, .psel, .penable, .pwrite,
        .pwdata, .prdata, .pready, .pslverr, .start_input, .sequential_start_input,
        .direct_select_inputs, .home_input, .data_number_select_inputs, .op_done,
        .motor_at_rest, .move_start, .move_data_no, .home_start, .home_position_flag,
        .home_incomplete_alarm, .irq, .home_mode, .home_speed, .home_accel,
        .home_start_speed, .home_offset, .home_dir, .index_aperture_input_use, .tim_use, .push_current);
    motion_gen_model gen_u (.clk_sys, .resetn, .move_start, .home_start, .op_delay,
        .op_done, .motor_at_rest);
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : test_done
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge clk_sys);
            if (pready === 1'b1) break;
        end
        if (i == 20) begin
            errors++;
            test_done();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        repeat (2) @(posedge clk_sys);
    endtask : apb
    // Pulse one start pin, optionally a direct pin while busy
    task automatic pin(input int p, input logic [5:0] late);
        int i;
        op_delay <= 8'(20 + $urandom % 21);
        case (p)
            0: start_input <= 1'b1;
            1: sequential_start_input <= 1'b1;
            2: home_input <= 1'b1;
            default: direct_select_inputs <= 6'h01 << (p - 3);
        endcase
        repeat (8) @(posedge clk_sys);
        start_input <= 1'b0;
        sequential_start_input <= 1'b0;
        home_input <= 1'b0;
        direct_select_inputs <= late;
        repeat (8) @(posedge clk_sys);
        direct_select_inputs <= 6'h00;
        for (i = 0; i < 300; i++) begin
            @(posedge clk_sys);
            if (exp_q.size() == 0 && motor_at_rest === 1'b1) break;
        end
        if (i == 300) begin
            errors++;
            test_done();
        end
        repeat (4) @(posedge clk_sys);
    endtask : pin
    always @(negedge clk_sys) begin
        if (move_start === 1'b1 || home_start === 1'b1) begin
            if (exp_q.size() == 0) begin
                chk("unexpected launch", 32'(move_data_no), 32'h80);
            end else begin
                chk("launch", home_start ? 32'h40 : 32'(move_data_no), 32'(exp_q.pop_front()));
            end
        end
    end
    initial begin
        void'($urandom(32'h704b));
        repeat (5) @(posedge clk_sys);
        resetn <= 1'b1;
        repeat (3) @(posedge clk_sys);
        for (k = 0; k < 12; k++) begin
            apb(1'b0, (k < 6) ? ra[k] : 8'(8'h20 + 4 * (k - 6)), 32'h0);
            chk("reset register", rd, (k < 6) ? rv[k] : 32'(k - 6));
        end
        $display("test reset values done");
        apb(1'b1, 8'h04, 32'h0);
        chk("home speed low", 32'(home_speed), 32'h3e8);
        apb(1'b1, 8'h04, 32'h000f_4240);
        chk("home speed", 32'(home_speed), 32'h000f_4240);
        apb(1'b1, 8'h14, 32'h0000_03e9);
        chk("push current", 32'(push_current), 32'h3e8);
        apb(1'b1, 8'h08, 32'h0000_0001);
        apb(1'b1, 8'h0c, 32'h000f_4241);
        chk("home accel", 32'(home_accel), 32'h1);
        chk("start speed", 32'(home_start_speed), 32'h1f4);
        apb(1'b1, 8'h00, 32'h0000_0006);
        apb(1'b0, 8'h00, 32'h0);
        chk("ctrl mode 3", rd, 32'h2);
        for (k = 0; k < 3; k++) begin
            apb(1'b1, 8'h00, 32'(k * 2 + 8));
            chk("mode", 32'({home_mode, home_dir}), 32'(k * 2 + 1));
        end
        apb(1'b1, 8'h10, 32'h0080_0000);
        chk("offset", 32'(home_offset), 32'h0080_0000);
        apb(1'b1, 8'h00, 32'h0000_0038);
        chk("index_aperture_input and tim", 32'({index_aperture_input_use, tim_use}), 32'h3);
        apb(1'b0, 8'h18, 32'h0);
        chk("unmapped", {rd[30:0], err}, 32'h1);
        $display("test register writes done");
        apb(1'b1, 8'h00, 32'h0000_000b);
        apb(1'b1, 8'h48, 32'h0000_0008);
        pin(0, 6'h00);
        chk("alarm irq", {home_incomplete_alarm, irq}, 32'h3);
        apb(1'b0, 8'h44, 32'h0);
        chk("irq status", rd, 32'h8);
        apb(1'b1, 8'h4c, 32'h0000_000f);
        apb(1'b1, 8'h00, 32'h0000_004a);
        chk("alarm cleared", {home_incomplete_alarm, irq}, 32'h0);
        $display("test alarm done");
        for (k = 0; k < 4; k++) begin
            n = (k == 0) ? 6'h3f : 6'($urandom);
            data_number_select_inputs <= n;
            exp_q.push_back({1'b0, n});
            pin(0, (k == 0) ? 6'h01 : 6'h00);
            exp_q.push_back({1'b0, n + 6'h01});
            pin(1, 6'h00);
            exp_q.push_back({1'b0, n + 6'h02});
            pin(1, 6'h00);
        end
        $display("test start and sequential done");
        apb(1'b1, 8'h28, 32'h0000_003f);
        for (k = 0; k < 6; k++) begin
            exp_q.push_back((k == 2) ? 7'h3f : 7'(k));
            pin(3 + k, 6'h00);
        end
        $display("test direct done");
        chk("flag before home", 32'(home_position_flag), 32'h0);
        exp_q.push_back(7'h40);
        pin(2, 6'h00);
        chk("flag after home", 32'(home_position_flag), 32'h1);
        apb(1'b1, 8'h00, 32'h0000_000b);
        data_number_select_inputs <= 6'h05;
        exp_q.push_back(7'h05);
        pin(0, 6'h00);
        chk("no alarm when homed", 32'(home_incomplete_alarm), 32'h0);
        apb(1'b0, 8'h40, 32'h0);
        chk("status", rd, 32'h501);
        $display("test homing done");
        test_done();
    end
endmodule : test_motion_start_handler
